// ===== hw/ptu_pkg.sv
// Constants, register map and tap table of the periodic tick unit
package ptu_pkg;

	// ==========================================================
	// Sizes
	localparam int PTU_DIV_STAGES = 15;
	localparam int PTU_RATE_W     = 3;
	localparam int PTU_TAP_W      = 4;
	localparam int PTU_ADDR_W     = 5;
	localparam int PTU_REG_W      = 8;
	localparam int PTU_EV_W       = 2;

	// ==========================================================
	// Register byte offsets
	localparam logic [PTU_ADDR_W-1:0] PTU_OFS_CTRL   = 5'h00;
	localparam logic [PTU_ADDR_W-1:0] PTU_OFS_STATUS = 5'h04;
	localparam logic [PTU_ADDR_W-1:0] PTU_OFS_CLEAR  = 5'h08;
	localparam logic [PTU_ADDR_W-1:0] PTU_OFS_ENABLE = 5'h0C;
	localparam logic [PTU_ADDR_W-1:0] PTU_OFS_COUNT  = 5'h10;

	// ==========================================================
	// timebase_control fields
	localparam int PTU_FLAG_BIT = 7;
	localparam int PTU_RATE_LSB = 4;
	localparam int PTU_ACK_BIT  = 3;
	localparam int PTU_IE_BIT   = 2;
	localparam int PTU_RUN_BIT  = 1;

	// Event bits of status, clear and enable
	localparam int PTU_EV_PERIOD  = 0;
	localparam int PTU_EV_REFUSED = 1;

	// ==========================================================
	// Reset values
	localparam logic [PTU_RATE_W-1:0] PTU_RATE_RST = 3'h0;
	localparam logic [PTU_EV_W-1:0]   PTU_EV_RST   = 2'h0;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] PTU_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PTU_RESP_SLVERR = 2'h2;
	localparam logic [1:0] PTU_RESP_DECERR = 2'h3;

	// Tap whose rising edge marks an event: half the ratio gives the half-period start
	function automatic logic [PTU_TAP_W-1:0] ptu_tap_bit(input logic [PTU_RATE_W-1:0] rate);
		logic [PTU_TAP_W-1:0] tap;
		tap = 4'hE;
		unique case (rate)
			3'h0: tap = 4'hE; // 32768
			3'h1: tap = 4'hC; // 8192
			3'h2: tap = 4'hA; // 2048
			3'h3: tap = 4'h6; // 128
			3'h4: tap = 4'h5; // 64
			3'h5: tap = 4'h4; // 32
			3'h6: tap = 4'h3; // 16
			3'h7: tap = 4'h2; // 8
		endcase
		return tap;
	endfunction : ptu_tap_bit

endpackage : ptu_pkg

// ===== hw/ptu_tick_if.sv
// Interface between control, crystal edge detector and divider
`timescale 1ns/10ps
interface ptu_tick_if #(parameter int STAGES = ptu_pkg::PTU_DIV_STAGES);
	logic                            tick;
	logic                            run;
	logic [ptu_pkg::PTU_RATE_W-1:0]  rate;
	logic                            active;
	logic                            overflow;
	logic [STAGES-1:0]               count;

	modport edge_src (output tick);
	modport div      (input tick, input run, input rate, input active,
	                  output overflow, output count);
	modport ctrl     (output run, output rate, output active,
	                  input overflow, input count);
endinterface : ptu_tick_if

// ===== hw/ptu_xtal_edge.sv
// Crystal clock synchroniser and rising edge detector
`timescale 1ns/10ps
module ptu_xtal_edge
(
	// Clock and reset
	input wire logic  aclk,
	input wire logic  aresetn,
	// Crystal pin
	input wire logic  crystal_ref_clock,
	// Tick out
	ptu_tick_if.edge_src tif
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
	} ptu_edge_state_t;

	ptu_edge_state_t st_reg;
	ptu_edge_state_t st_next;

	always_comb
	begin
		st_next       = st_reg;
		st_next.sync1 = crystal_ref_clock;
		st_next.sync2 = st_reg.sync1;
		st_next.last  = st_reg.sync2;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// Crystal is far slower than aclk, so one pulse per crystal period
	assign tif.tick = st_reg.sync2 & ~st_reg.last;
endmodule : ptu_xtal_edge

// ===== hw/ptu_divider.sv
// Fifteen stage divider chain with selectable tap
`timescale 1ns/10ps
module ptu_divider #(parameter int STAGES = ptu_pkg::PTU_DIV_STAGES)
(
	// Clock and reset
	input wire logic  aclk,
	input wire logic  aresetn,
	// Divider side
	ptu_tick_if.div   tif
);
	typedef struct packed {
		logic [STAGES-1:0] count;
		logic              overflow;
	} ptu_div_state_t;

	ptu_div_state_t st_reg;
	ptu_div_state_t st_next;
	logic [ptu_pkg::PTU_TAP_W-1:0] tap;

	always_comb
	begin
		tap              = ptu_pkg::ptu_tap_bit(tif.rate);
		st_next          = st_reg;
		st_next.overflow = 1'b0;
		if (!tif.run)
			st_next.count = '0;
		else if (tif.tick && tif.active)
		begin
			st_next.count    = st_reg.count + 1'b1;
			st_next.overflow = st_next.count[tap] & ~st_reg.count[tap];
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign tif.overflow = st_reg.overflow;
	assign tif.count    = st_reg.count;
endmodule : ptu_divider

// ===== hw/ptu_periodic_tick_unit.sv
// Periodic tick unit top: AXI4-Lite registers, flag, interrupts, power modes
`timescale 1ns/10ps
module ptu_periodic_tick_unit
(
	// Clock and reset
	input wire logic                            aclk,
	input wire logic                            aresetn,
	// AXI4-Lite write address
	input wire logic                            s_axi_awvalid,
	output logic                                s_axi_awready,
	input wire logic [ptu_pkg::PTU_ADDR_W-1:0]  s_axi_awaddr,
	input wire logic [2:0]                      s_axi_awprot,
	// AXI4-Lite write data
	input wire logic                            s_axi_wvalid,
	output logic                                s_axi_wready,
	input wire logic [31:0]                     s_axi_wdata,
	input wire logic [3:0]                      s_axi_wstrb,
	// AXI4-Lite write response
	output logic                                s_axi_bvalid,
	input wire logic                            s_axi_bready,
	output logic [1:0]                          s_axi_bresp,
	// AXI4-Lite read address
	input wire logic                            s_axi_arvalid,
	output logic                                s_axi_arready,
	input wire logic [ptu_pkg::PTU_ADDR_W-1:0]  s_axi_araddr,
	input wire logic [2:0]                      s_axi_arprot,
	// AXI4-Lite read data
	output logic                                s_axi_rvalid,
	input wire logic                            s_axi_rready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	// Crystal reference
	input wire logic                            crystal_ref_clock,
	// Power modes, from same-clock system logic
	input wire logic                            wait_mode,
	input wire logic                            stop_mode,
	input wire logic                            osc_run_in_stop,
	// Interrupts
	output logic                                period_irq,
	output logic                                irq
);
	localparam int RW = ptu_pkg::PTU_REG_W;
	localparam int EW = ptu_pkg::PTU_EV_W;
	localparam int AW = ptu_pkg::PTU_ADDR_W;
	localparam int CW = ptu_pkg::PTU_DIV_STAGES;

	// ==========================================================
	// State
	typedef struct packed {
		// Write channel
		logic                            aw_seen;
		logic [AW-1:0]                   awaddr;
		logic                            w_seen;
		logic [RW-1:0]                   wdata;
		logic                            wlane0;
		logic                            bvalid;
		logic [1:0]                      bresp;
		// Read channel
		logic                            rvalid;
		logic [RW*2-1:0]                 rdata;
		logic [1:0]                      rresp;
		// timebase_control
		logic                            run;
		logic [ptu_pkg::PTU_RATE_W-1:0]  rate;
		logic                            irq_en;
		logic                            flag;
		// Event status and enable
		logic [EW-1:0]                   ev_status;
		logic [EW-1:0]                   ev_enable;
	} ptu_top_state_t;

	ptu_top_state_t st_reg;
	ptu_top_state_t st_next;

	// ==========================================================
	// Crystal edge and divider
	ptu_tick_if #(.STAGES(CW)) tif ();

	ptu_xtal_edge u_edge
	(
		.aclk              (aclk),
		.aresetn           (aresetn),
		.crystal_ref_clock (crystal_ref_clock),
		.tif               (tif.edge_src)
	);

	ptu_divider #(.STAGES(CW)) u_div
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.tif     (tif.div)
	);

	logic osc_active;
	logic regs_locked;

	// Oscillator keeps running unless stop without the keep-alive option
	assign osc_active  = ~stop_mode | osc_run_in_stop;
	// Bus side of the block is closed in both low power modes
	assign regs_locked = wait_mode | stop_mode;

	assign tif.run    = st_reg.run;
	assign tif.rate   = st_reg.rate;
	// Wait mode leaves the divider free to count
	assign tif.active = osc_active;

	// ==========================================================
	// Bus handshakes
	assign s_axi_awready = ~st_reg.aw_seen & ~st_reg.bvalid;
	assign s_axi_wready  = ~st_reg.w_seen & ~st_reg.bvalid;
	assign s_axi_arready = ~st_reg.rvalid;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = {16'h0000, st_reg.rdata};
	assign s_axi_rresp   = st_reg.rresp;

	// ==========================================================
	// Interrupt outputs
	assign period_irq = st_reg.flag & st_reg.irq_en;
	assign irq        = |(st_reg.ev_status & st_reg.ev_enable);

	// ==========================================================
	// Next state
	logic            aw_have;
	logic            w_have;
	logic [AW-1:0]   wr_addr;
	logic [RW-1:0]   wr_data;
	logic            wr_lane0;
	logic            do_write;
	logic            do_read;
	logic            ack_clear;
	logic [EW-1:0]   ev_set;
	logic [EW-1:0]   ev_clr;
	logic [RW-1:0]   ctrl_view;

	always_comb
	begin
		st_next   = st_reg;
		ack_clear = 1'b0;
		ev_set    = '0;
		ev_clr    = '0;

		// Address and data may arrive in either order or together
		aw_have  = st_reg.aw_seen | (s_axi_awvalid & s_axi_awready);
		w_have   = st_reg.w_seen | (s_axi_wvalid & s_axi_wready);
		wr_addr  = st_reg.aw_seen ? st_reg.awaddr : s_axi_awaddr;
		wr_data  = st_reg.w_seen ? st_reg.wdata : s_axi_wdata[RW-1:0];
		wr_lane0 = st_reg.w_seen ? st_reg.wlane0 : s_axi_wstrb[0];
		do_write = aw_have & w_have & ~st_reg.bvalid;
		do_read  = s_axi_arvalid & s_axi_arready;

		// Acknowledge bit always reads as zero
		ctrl_view                        = '0;
		ctrl_view[ptu_pkg::PTU_FLAG_BIT] = st_reg.flag;
		ctrl_view[ptu_pkg::PTU_RATE_LSB +: ptu_pkg::PTU_RATE_W] = st_reg.rate;
		ctrl_view[ptu_pkg::PTU_IE_BIT]   = st_reg.irq_en;
		ctrl_view[ptu_pkg::PTU_RUN_BIT]  = st_reg.run;

		// Hold halves of a write that is not yet complete
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_next.aw_seen = 1'b1;
			st_next.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_next.w_seen = 1'b1;
			st_next.wdata  = s_axi_wdata[RW-1:0];
			st_next.wlane0 = s_axi_wstrb[0];
		end

		// ------------------------------------------------------
		// Write
		if (st_reg.bvalid && s_axi_bready)
			st_next.bvalid = 1'b0;
		if (do_write)
		begin
			st_next.aw_seen = 1'b0;
			st_next.w_seen  = 1'b0;
			st_next.bvalid  = 1'b1;
			st_next.bresp   = ptu_pkg::PTU_RESP_OKAY;
			if (regs_locked)
			begin
				// Refused; no register changes except the refused event bit of the event status
				st_next.bresp                   = ptu_pkg::PTU_RESP_SLVERR;
				ev_set[ptu_pkg::PTU_EV_REFUSED] = 1'b1;
			end
			else
			begin
				unique case (wr_addr)
					ptu_pkg::PTU_OFS_CTRL:
					begin
						if (wr_lane0)
						begin
							// Rate may change mid-run; software is expected to stop first
							st_next.rate   = wr_data[ptu_pkg::PTU_RATE_LSB +:
							                         ptu_pkg::PTU_RATE_W];
							st_next.irq_en = wr_data[ptu_pkg::PTU_IE_BIT];
							st_next.run    = wr_data[ptu_pkg::PTU_RUN_BIT];
							// Writing zero to acknowledge leaves the flag alone
							ack_clear      = wr_data[ptu_pkg::PTU_ACK_BIT];
						end
					end
					ptu_pkg::PTU_OFS_CLEAR:
					begin
						if (wr_lane0)
							ev_clr = wr_data[EW-1:0];
					end
					ptu_pkg::PTU_OFS_ENABLE:
					begin
						if (wr_lane0)
							st_next.ev_enable = wr_data[EW-1:0];
					end
					ptu_pkg::PTU_OFS_STATUS,
					ptu_pkg::PTU_OFS_COUNT:
					begin
						// Read-only: write accepted and dropped
						st_next.bresp = ptu_pkg::PTU_RESP_OKAY;
					end
					default:
						st_next.bresp = ptu_pkg::PTU_RESP_DECERR;
				endcase
			end
		end

		// ------------------------------------------------------
		// Read
		if (st_reg.rvalid && s_axi_rready)
			st_next.rvalid = 1'b0;
		if (do_read)
		begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = '0;
			st_next.rresp  = ptu_pkg::PTU_RESP_OKAY;
			if (regs_locked)
			begin
				st_next.rresp                   = ptu_pkg::PTU_RESP_SLVERR;
				ev_set[ptu_pkg::PTU_EV_REFUSED] = 1'b1;
			end
			else
			begin
				unique case (s_axi_araddr)
					ptu_pkg::PTU_OFS_CTRL:
						st_next.rdata = {8'h00, ctrl_view};
					ptu_pkg::PTU_OFS_STATUS:
						st_next.rdata = {{(RW*2-EW){1'b0}}, st_reg.ev_status};
					ptu_pkg::PTU_OFS_ENABLE:
						st_next.rdata = {{(RW*2-EW){1'b0}}, st_reg.ev_enable};
					ptu_pkg::PTU_OFS_COUNT:
						st_next.rdata = {1'b0, tif.count};
					ptu_pkg::PTU_OFS_CLEAR:
						st_next.rdata = '0;
					default:
						st_next.rresp = ptu_pkg::PTU_RESP_DECERR;
				endcase
			end
		end

		// ------------------------------------------------------
		// Period flag: only a rollover sets it, and a set beats a clear
		ev_set[ptu_pkg::PTU_EV_PERIOD] = tif.overflow;
		st_next.flag = (st_reg.flag & ~ack_clear) | tif.overflow;

		// Sticky events, set wins over clear
		st_next.ev_status = (st_reg.ev_status & ~ev_clr) | ev_set;
	end

	// ==========================================================
	// Registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_reg           <= '0;
			st_reg.rate      <= ptu_pkg::PTU_RATE_RST;
			st_reg.run       <= 1'b0;
			st_reg.irq_en    <= 1'b0;
			st_reg.ev_status <= ptu_pkg::PTU_EV_RST;
			st_reg.ev_enable <= ptu_pkg::PTU_EV_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
endmodule : ptu_periodic_tick_unit

// ===== tb/ptu_periodic_tick_unit_monitor.sv
// Port checker of the periodic tick unit, bound to its top module
`timescale 1ns/10ps
module ptu_periodic_tick_unit_monitor
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [4:0]  s_axi_awaddr,
	input wire logic [2:0]  s_axi_awprot,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// Read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [4:0]  s_axi_araddr,
	input wire logic [2:0]  s_axi_arprot,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	// Pins
	input wire logic        crystal_ref_clock,
	input wire logic        wait_mode,
	input wire logic        stop_mode,
	input wire logic        osc_run_in_stop,
	input wire logic        period_irq,
	input wire logic        irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Helpers
	wire logic aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire logic ar_t = s_axi_arvalid && s_axi_arready;
	wire logic lowp = wait_mode || stop_mode;

	// ==========================================================
	// Properties
	AST_B_ANSWER: assert property (aw_w |=> s_axi_bvalid)
		else $error("write not answered");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer open");
	AST_LOWP_READ: assert property (ar_t && lowp |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("read in low power not refused");
	AST_LOWP_WRITE: assert property (aw_w && lowp |=> s_axi_bresp == 2'h2)
		else $error("write in low power not refused");
	AST_ACK_ZERO: assert property (ar_t && !lowp && s_axi_araddr == 5'h00 |=> !s_axi_rdata[3] && !s_axi_rdata[0])
		else $error("acknowledge bit read back");
	AST_IRQ_HOLD: assert property ($fell(period_irq) |-> $rose(s_axi_bvalid))
		else $error("request dropped without write");
	AST_RESET_CLEAR: assert property ($rose(aresetn) |-> !period_irq && !irq)
		else $error("request after reset");
	AST_IRQ_CAUSE: assert property ($rose(period_irq) |-> $rose(s_axi_bvalid) || ($past(crystal_ref_clock, 4) && !$past(crystal_ref_clock, 5)))
		else $error("request without cause");
endmodule : ptu_periodic_tick_unit_monitor

bind ptu_periodic_tick_unit ptu_periodic_tick_unit_monitor u_mon (.*);

// ===== tb/ptu_periodic_tick_unit_tb_top.sv
// Self-checking bench of the periodic tick unit
`timescale 1ns/10ps
module ptu_periodic_tick_unit_tb_top;
	// ==========================================================
	// Signals
	logic        aclk, aresetn, period_irq, irq;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [4:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        crystal_ref_clock, wait_mode, stop_mode, osc_run_in_stop;
	int          failures, n_tests;
	// Rate 0 entry is a shortened run: a full half period is too long
	int          hf [8] = '{4101, 4096, 1024, 64, 32, 16, 8, 4};
	localparam logic [1:0] OK = ptu_pkg::PTU_RESP_OKAY;
	localparam logic [1:0] SE = ptu_pkg::PTU_RESP_SLVERR;
	localparam logic [1:0] DE = ptu_pkg::PTU_RESP_DECERR;
	localparam logic [4:0] CT = ptu_pkg::PTU_OFS_CTRL;
	localparam logic [4:0] ST = ptu_pkg::PTU_OFS_STATUS;
	localparam logic [4:0] CL = ptu_pkg::PTU_OFS_CLEAR;
	localparam logic [4:0] EN = ptu_pkg::PTU_OFS_ENABLE;
	localparam logic [4:0] CN = ptu_pkg::PTU_OFS_COUNT;

	ptu_periodic_tick_unit dut (.*);

	always #5 aclk = ~aclk;

	// ==========================================================
	// Tasks
	task automatic end_of_test();
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic stuck();
		failures++;
		end_of_test();
	endtask : stuck

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b, ta, tw, tb;
		int   k;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		k = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (b && k < 50)
		begin
			@(negedge aclk);
			k++;
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			tb = !aw && !w && s_axi_bvalid;
			if (tb)
				chk(s_axi_bresp, er);
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			// Response ready stays high: a following call would raise it again in this step
			aw = aw && !ta;
			w = w && !tw;
			b = b && !tb;
		end
		if (b)
			stuck();
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, r, ta, tb;
		int   k;
		ar = 1'b1;
		r = 1'b1;
		k = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (r && k < 50)
		begin
			@(negedge aclk);
			k++;
			ta = ar && s_axi_arready;
			tb = !ar && s_axi_rvalid;
			if (tb)
			begin
				chk(s_axi_rdata, ed);
				chk(s_axi_rresp, er);
			end
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			ar = ar && !ta;
			r = r && !tb;
		end
		if (r)
			stuck();
	endtask : rd

	// Crystal edges, each phase 3 clocks so the synchroniser sees every edge
	task automatic xt(input int n);
		repeat (n)
		begin
			crystal_ref_clock <= 1'b1;
			repeat (3) @(posedge aclk);
			crystal_ref_clock <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask : xt

	task automatic rst();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask : rst

	// ==========================================================
	// Sequence
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		{crystal_ref_clock, wait_mode, stop_mode, osc_run_in_stop} = '0;
		s_axi_wstrb = 4'hF;
		failures = 0;
		n_tests = 0;
		rst();
		rd(CT, 32'h0, OK);
		rd(CN, 32'h0, OK);
		rd(ST, 32'h0, OK);
		rd(EN, 32'h0, OK);
		wr(CT, 32'h76, OK);
		xt(3);
		rd(CN, 32'h3, OK);
		xt(1);
		rd(CT, 32'hF6, OK);
		chk(period_irq, 1'b1);
		wr(CT, 32'h76, OK);
		chk(period_irq, 1'b1);
		wr(CT, 32'h7E, OK);
		chk(period_irq, 1'b0);
		wr(CT, 32'hF6, OK);
		rd(CT, 32'h76, OK);
		xt(7);
		rd(CT, 32'h76, OK);
		xt(1);
		rd(CT, 32'hF6, OK);
		rd(ST, 32'h1, OK);
		chk(irq, 1'b0);
		wr(EN, 32'h1, OK);
		rd(EN, 32'h1, OK);
		chk(irq, 1'b1);
		// Lane 0 strobe low: write answered and ignored
		s_axi_wstrb <= 4'hE;
		wr(EN, 32'h0, OK);
		s_axi_wstrb <= 4'hF;
		rd(EN, 32'h1, OK);
		wr(CL, 32'h1, OK);
		rd(ST, 32'h0, OK);
		chk(irq, 1'b0);
		rd(CL, 32'h0, OK);
		wr(CT, 32'h7C, OK);
		rd(CN, 32'h0, OK);
		wr(CT, 32'h76, OK);
		xt(3);
		rd(CN, 32'h3, OK);
		wait_mode <= 1'b1;
		rd(CT, 32'h0, SE);
		wr(CT, 32'h0, SE);
		xt(1);
		wait_mode <= 1'b0;
		rd(CT, 32'hF6, OK);
		rd(ST, 32'h3, OK);
		chk(irq, 1'b1);
		stop_mode <= 1'b1;
		xt(2);
		rd(CT, 32'h0, SE);
		stop_mode <= 1'b0;
		rd(CN, 32'h4, OK);
		stop_mode <= 1'b1;
		osc_run_in_stop <= 1'b1;
		xt(2);
		stop_mode <= 1'b0;
		rd(CN, 32'h6, OK);
		rd(5'h14, 32'h0, DE);
		wr(5'h14, 32'h1, DE);
		wr(CN, 32'h0, OK);
		rst();
		rd(CT, 32'h0, OK);
		chk(period_irq, 1'b0);
		for (int r = 0; r < 8; r++)
		begin
			wr(CT, 32'(r << 4) | 32'h2, OK);
			xt(hf[r] - 1);
			rd(CT, 32'(r << 4) | 32'h2, OK);
			if (r > 0)
			begin
				xt(1);
				rd(CT, 32'(r << 4) | 32'h82, OK);
			end
			wr(CT, 32'h8, OK);
		end
		end_of_test();
	end
endmodule : ptu_periodic_tick_unit_tb_top
